/* File: adcsr_consts.svh */
// Timing and layout constants for the converter serial readout block
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH
`define ADCSR_CLK_NS          10
`define ADCSR_T_CONV_FAST_NS  12500000
`define ADCSR_T_CONV_SLOW_NS  100000000
`define ADCSR_T_UPDATE_NS     39000
`define ADCSR_T_CAL_FAST_NS   101280000
`define ADCSR_T_CAL_SLOW_NS   801020000
`define ADCSR_T_STBY_NS       20000
`define ADCSR_T_WAKE_FAST_NS  52510000
`define ADCSR_T_WAKE_SLOW_NS  401800000
`define ADCSR_RES_BITS        20
`define ADCSR_ONES_LAST       24
`define ADCSR_CAL_EDGE        26
`define ADCSR_CNT_IDLE        5'h1f
`define ADCSR_TIMER_W         27
`endif

/* File: adcsr_host_model.sv */
// Host-side model that clocks the serial readout link
`timescale 1ns/1ps
module adcsr_host_model (
  input  wire logic i_sdo,
  output logic      o_sclk
);
  initial o_sclk = 1'b0;
  // short bursts after ready
  // Bit sampled late in each period, well after the pin has settled
  task automatic clock_bits(input int n, output logic [23:0] bits);
    bits = '0;
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
      #62.5 bits = {bits[22:0], i_sdo};
    end
  endtask : clock_bits
  task automatic hold(input logic lvl);
    o_sclk = lvl;
  endtask : hold
endmodule : adcsr_host_model

/* File: adcsr_pkg.sv */
// Types shared by the converter serial readout block
package adcsr_pkg;
  typedef enum logic [1:0] {
    ST_CONV = 2'b00,
    ST_CAL  = 2'b01,
    ST_STBY = 2'b10,
    ST_WAKE = 2'b11
  } adcsr_state_e;

  typedef struct packed {
    logic analog_disconnect;
    logic analog_power_down;
    logic calibrating;
    logic standby;
  } adcsr_ctrl_s;
endpackage : adcsr_pkg

/* File: adcsr_readout.sv */
// Serial readout, calibration and standby control of a 20-bit converter
//
// What this block does
// [R1] Shared output goes low when a fresh result is presented.
// [R2] First rising clock edge after ready shows MSB; each later edge advances.
// [R3] An edge after the 20 bits forces output high until next result.
// [R4] Clock edges 21 through 24 output ones.
// [R5] After exactly 20 edges output holds last bit until the update forces high.
// [R6] Converts continuously; unread result overwritten each period, 12.5 or 100 ms.
// [R7] Host must not clock during the 39 us update window.
// [R8] Host may stop early but must finish within the conversion period.
// [R9] Two extra edges after 24 request calibration, accepted only while converting, before the next result.
// [R10] Output stays high on the 25th clock edge.
// [R11] Calibration starts on the falling edge of the 26th clock pulse.
// [R12] Host may clock after the 26th but should keep activity low.
// [R13] Calibration disconnects analog inputs and applies internal signal.
// [R14] Ready 101.28 or 801.02 ms after calibration start; result settled.
// [R15] Host raises clock for standby within 12.44 or 99.94 ms after ready.
// [R16] Standby entered after clock held high at least 20 us.
// [R17] Standby powers down analog circuitry, clock source keeps running.
// [R18] Output held high during standby.
// [R19] Standby lasts while clock high; clock low wakes the device.
// [R20] Host may enter standby mid readout.
// [R21] Ready 52.51 or 401.8 ms after wake; first result valid.
// [R22] All intervals scale with the device clock period.
// [R23] Rate pin low selects slow rate, high selects fast rate.
// [R24] Result is 20-bit two's complement, clipped at full scale.
// [R25] Edge count selects output bit, cleared on each new result.
`include "adcsr_consts.svh"
`timescale 1ns/1ps
module adcsr_readout #(
  parameter logic [26:0] P_CONV_FAST = 27'(`ADCSR_T_CONV_FAST_NS / `ADCSR_CLK_NS),
  parameter logic [26:0] P_CONV_SLOW = 27'(`ADCSR_T_CONV_SLOW_NS / `ADCSR_CLK_NS),
  parameter logic [26:0] P_CAL_FAST  =
    27'((`ADCSR_T_CAL_FAST_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS),
  parameter logic [26:0] P_CAL_SLOW  =
    27'((`ADCSR_T_CAL_SLOW_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS),
  parameter logic [26:0] P_WAKE_FAST = 27'(`ADCSR_T_WAKE_FAST_NS / `ADCSR_CLK_NS),
  parameter logic [26:0] P_WAKE_SLOW = 27'(`ADCSR_T_WAKE_SLOW_NS / `ADCSR_CLK_NS),
  parameter int          P_FILT_W    = 24
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_clk_en,
  input  wire logic                       i_serial_clk,
  input  wire logic                       i_rate_fast,
  input  wire logic signed [P_FILT_W-1:0] i_filter_value,
  output logic                            o_ready_and_serial_out,
  output adcsr_pkg::adcsr_ctrl_s          o_ctrl
);
  localparam int TW = `ADCSR_TIMER_W;
  // Least times round up to whole cycles
  localparam logic [TW-1:0] UPD_CYC =
    TW'((`ADCSR_T_UPDATE_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS);
  localparam logic [11:0] STBY_CYC =
    12'((`ADCSR_T_STBY_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS);

  initial begin
    if (P_FILT_W < `ADCSR_RES_BITS || P_CONV_FAST <= UPD_CYC || P_CONV_SLOW <= UPD_CYC
        || P_CAL_FAST == '0 || P_CAL_SLOW == '0 || P_WAKE_FAST == '0 || P_WAKE_SLOW == '0)
      $error("adcsr_readout: parameter values not supported");
  end

  // [R23] rate pick
  function automatic logic [TW-1:0] pick(input logic fast, input logic [TW-1:0] f,
                                         input logic [TW-1:0] s);
    pick = fast ? f : s;
  endfunction : pick

  // [R24] full scale clip
  function automatic logic [19:0] clip20(input logic signed [P_FILT_W-1:0] v);
    if (v > $signed(P_FILT_W'(20'sh7ffff)))
      clip20 = 20'h7ffff;
    else if (v < -$signed(P_FILT_W'(20'sh7ffff)) - 1)
      clip20 = 20'h80000;
    else
      clip20 = v[19:0];
  endfunction : clip20

  // Pin synchronisers, three stages, level accepted once stages two and three agree
  logic [2:0] sck_q, sck_d, rate_q, rate_d;
  logic       sck_lvl_q, sck_lvl_d, rate_lvl_q, rate_lvl_d;
  logic       sck_rise, sck_fall;

  always_comb begin
    sck_d      = {sck_q[1:0], i_serial_clk};
    rate_d     = {rate_q[1:0], i_rate_fast};
    sck_lvl_d  = (sck_q[1] == sck_q[2]) ? sck_q[2] : sck_lvl_q;
    rate_lvl_d = (rate_q[1] == rate_q[2]) ? rate_q[2] : rate_lvl_q;
    sck_rise   = i_clk_en & sck_lvl_d & ~sck_lvl_q;
    sck_fall   = i_clk_en & ~sck_lvl_d & sck_lvl_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_q      <= 3'h0;
      rate_q     <= 3'h0;
      sck_lvl_q  <= 1'b0;
      rate_lvl_q <= 1'b0;
    end else if (i_clk_en) begin
      sck_q      <= sck_d;
      rate_q     <= rate_d;
      sck_lvl_q  <= sck_lvl_d;
      rate_lvl_q <= rate_lvl_d;
    end
  end

  // Main sequencer
  adcsr_pkg::adcsr_state_e st_q, st_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [4:0]    cnt_q, cnt_d;
  logic [19:0]   res_q, res_d;
  logic [11:0]   hi_q, hi_d;
  logic          out_q, out_d;
  logic          present, in_update;
  logic [TW-1:0] conv_len;

  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    cnt_d     = cnt_q;
    res_d     = res_q;
    hi_d      = hi_q;
    present   = 1'b0;
    // [R22] counts are in device clock cycles, so they scale with its period
    conv_len  = pick(rate_lvl_q, P_CONV_FAST, P_CONV_SLOW);
    in_update = (st_q == adcsr_pkg::ST_CONV) && (tmr_q >= conv_len - UPD_CYC);
    if (i_clk_en) begin
      unique case (st_q)
        adcsr_pkg::ST_CONV: begin
          // [R6] free running period, result overwritten
          if (tmr_q >= conv_len - 1'b1) begin
            present = 1'b1;
          end else begin
            tmr_d = tmr_q + 1'b1;
          end
          // [R25] count edges, saturating
          if (sck_rise && !in_update && cnt_q != `ADCSR_CNT_IDLE)
            cnt_d = cnt_q + 5'h1;
          // [R9] [R11] start calibration on falling edge of the 26th pulse
          if (sck_fall && cnt_q == 5'(`ADCSR_CAL_EDGE)) begin
            st_d  = adcsr_pkg::ST_CAL;
            tmr_d = '0;
            cnt_d = `ADCSR_CNT_IDLE;
          end
          // [R16] standby once clock high long enough
          if (sck_lvl_q && hi_q >= STBY_CYC - 12'h1) begin
            st_d  = adcsr_pkg::ST_STBY;
            cnt_d = `ADCSR_CNT_IDLE;
          end
          hi_d = sck_lvl_q ? hi_q + 12'h1 : 12'h0;
        end
        adcsr_pkg::ST_CAL: begin
          // [R14] settled result after calibration time
          if (tmr_q >= pick(rate_lvl_q, P_CAL_FAST, P_CAL_SLOW) - 1'b1)
            present = 1'b1;
          else
            tmr_d = tmr_q + 1'b1;
        end
        adcsr_pkg::ST_STBY: begin
          // [R19] clock low wakes the device
          if (sck_fall) begin
            st_d  = adcsr_pkg::ST_WAKE;
            tmr_d = '0;
          end
        end
        adcsr_pkg::ST_WAKE: begin
          // [R21] ready after wake time
          if (tmr_q >= pick(rate_lvl_q, P_WAKE_FAST, P_WAKE_SLOW) - 1'b1)
            present = 1'b1;
          else
            tmr_d = tmr_q + 1'b1;
        end
      endcase
      if (present) begin
        st_d  = adcsr_pkg::ST_CONV;
        tmr_d = '0;
        hi_d  = 12'h0;
        // [R25] clear count on new result
        cnt_d = 5'h0;
        res_d = clip20(i_filter_value);
      end
    end
  end

  // Output bit follows the next count so the pin changes with the edge
  // [R18] high unless converting
  always_comb begin
    out_d = 1'b1;
    if (st_d == adcsr_pkg::ST_CONV && !present && in_update) begin
      out_d = 1'b1;
    end else if (st_d == adcsr_pkg::ST_CONV) begin
      // [R1] ready low; [R2] MSB first; [R5] hold last bit
      if (cnt_d == 5'h0)
        out_d = 1'b0;
      else if (cnt_d <= 5'(`ADCSR_RES_BITS))
        out_d = res_d[5'(`ADCSR_RES_BITS) - cnt_d];
      // [R3] [R4] [R10] ones beyond the data bits
      else
        out_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q  <= adcsr_pkg::ST_CONV;
      tmr_q <= '0;
      cnt_q <= `ADCSR_CNT_IDLE;
      res_q <= 20'h00000;
      hi_q  <= 12'h000;
      out_q <= 1'b1;
    end else if (i_clk_en) begin
      st_q  <= st_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      hi_q  <= hi_d;
      out_q <= out_d;
    end
  end

  assign o_ready_and_serial_out = out_q;
  // [R13] [R17] analog controls follow the state
  assign o_ctrl.analog_disconnect = (st_q == adcsr_pkg::ST_CAL);
  assign o_ctrl.analog_power_down = (st_q == adcsr_pkg::ST_STBY);
  assign o_ctrl.calibrating       = (st_q == adcsr_pkg::ST_CAL);
  assign o_ctrl.standby           = (st_q == adcsr_pkg::ST_STBY);

  a_ready_low: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R1]
    (i_clk_en && present) |=> (!o_ready_and_serial_out && cnt_q == 5'h0))
    else $error("ready not low after new result");
  a_data_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R2]
    (st_q == adcsr_pkg::ST_CONV && !in_update && cnt_q >= 5'h1 && cnt_q <= 5'h14)
    |-> (o_ready_and_serial_out == res_q[5'h14 - cnt_q]))
    else $error("serial bit does not match result");
  a_ones_tail: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R4]
    (st_q == adcsr_pkg::ST_CONV && cnt_q >= 5'h15) |-> o_ready_and_serial_out)
    else $error("output not high past data bits");
  a_update_high: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R5]
    (in_update && $past(in_update)) |-> o_ready_and_serial_out)
    else $error("output not high in update window");
  a_cal_start: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R11]
    (st_q == adcsr_pkg::ST_CONV && sck_fall && cnt_q == 5'h1a && !present)
    |=> (st_q == adcsr_pkg::ST_CAL && o_ctrl.analog_disconnect))
    else $error("calibration did not start on 26th fall");
  a_stby_high: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R18]
    (st_q == adcsr_pkg::ST_STBY) |-> (o_ready_and_serial_out && o_ctrl.analog_power_down))
    else $error("standby output not high");
  a_wake_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R19]
    (st_q == adcsr_pkg::ST_STBY && sck_fall) |=> (st_q == adcsr_pkg::ST_WAKE && tmr_q == '0))
    else $error("no wake on clock low");
  a_stby_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R16]
    (st_q == adcsr_pkg::ST_CONV && i_clk_en && !present && sck_lvl_q
     && hi_q == STBY_CYC - 12'h1) |=> (st_q == adcsr_pkg::ST_STBY))
    else $error("standby not entered after hold time");
  a_stay_stby: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R19]
    (st_q == adcsr_pkg::ST_STBY && !sck_fall) |=> (st_q == adcsr_pkg::ST_STBY))
    else $error("standby left while clock high");

  // Enable low must freeze every counter, else intervals would stretch unevenly
  a_freeze_state: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R22]
    (!i_clk_en) |=> ($stable(st_q) && $stable(tmr_q) && $stable(cnt_q) && $stable(out_q)))
    else $error("state moved while enable low");
  a_cnt_step: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R25]
    (st_q == adcsr_pkg::ST_CONV && sck_rise && !in_update && !present && cnt_q != 5'h1f)
    |=> (cnt_q == $past(cnt_q) + 5'h1))
    else $error("edge count did not advance");
  // Edges inside the update window are dropped so a late host cannot skew the count
  a_update_ignore: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R25]
    (st_q == adcsr_pkg::ST_CONV && in_update && sck_rise && !present) |=> $stable(cnt_q))
    else $error("edge counted in update window");
  a_hold_last: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R5]
    (st_q == adcsr_pkg::ST_CONV && i_clk_en && !present && !in_update && !sck_rise
     && st_d == adcsr_pkg::ST_CONV && cnt_q == 5'h14) |=> $stable(o_ready_and_serial_out))
    else $error("last bit not held");
  a_cal_ctrl: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R13]
    (st_q == adcsr_pkg::ST_CAL)
    |-> (o_ctrl.analog_disconnect && o_ctrl.calibrating && o_ready_and_serial_out))
    else $error("calibration controls wrong");
  a_stby_pwr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R17]
    (st_q == adcsr_pkg::ST_STBY) |-> (o_ctrl.standby && !o_ctrl.analog_disconnect))
    else $error("standby controls wrong");
  // The pin must not signal ready before the wake interval is over
  a_wake_high: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // [R21]
    (st_q == adcsr_pkg::ST_WAKE) |-> o_ready_and_serial_out)
    else $error("output low while waking");
endmodule : adcsr_readout

/* File: tb.sv */
// Self-checking bench for the converter serial readout block
`timescale 1ns/1ps
module tb;
  logic                   i_ref_clk = 1'b0;
  logic                   i_rstn = 1'b0;
  logic                   i_rate_fast = 1'b1;
  logic                   i_clk_en = 1'b1;
  logic signed [23:0]     i_filter_value = 24'sh0;
  logic                   sclk;
  logic                   dout;
  adcsr_pkg::adcsr_ctrl_s o_ctrl;
  logic [23:0]            bits;
  int                     n_fail = 0;
  int                     n_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  // Short periods keep the run small; the update window stays at 3900
  adcsr_readout #(.P_CONV_FAST(27'h1388), .P_CONV_SLOW(27'h1770), .P_CAL_FAST(27'h12c),
    .P_WAKE_FAST(27'hc8)) DUT (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_serial_clk(sclk),
    .i_rate_fast(i_rate_fast), .i_filter_value(i_filter_value),
    .o_ready_and_serial_out(dout), .o_ctrl(o_ctrl));
  adcsr_host_model host (.i_sdo(dout), .o_sclk(sclk));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Cycles until the pin next falls from high to low
  task automatic wait_fall(output int n);
    n = 0;
    while (dout !== 1'b1 && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    while (dout !== 1'b0 && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 20000) begin
      n_fail++;
      conclude();
    end
  endtask : wait_fall
  task automatic t_read(input logic [23:0] v, input logic [19:0] exp);
    int n;
    @(posedge i_ref_clk);
    i_filter_value <= v;
    wait_fall(n);
    host.clock_bits(24, bits);
    check("data", bits[23:4], exp);
    check("ones", bits[3:0], 4'hf);
    check("forced high", dout, 1'b1);
  endtask : t_read
  task automatic t_short();
    int n;
    @(posedge i_ref_clk);
    i_filter_value <= 24'sh000002;
    wait_fall(n);
    host.clock_bits(20, bits);
    check("short data", bits[19:0], 20'h00002);
    repeat (500) @(posedge i_ref_clk);
    check("last bit held", dout, 1'b0);
    wait_fall(n);
    host.clock_bits(21, bits);
    repeat (500) @(posedge i_ref_clk);
    check("bit 21 high", {bits[1:0], dout}, 3'b011);
  endtask : t_short
  task automatic t_period(input logic fast, input int exp);
    int n;
    @(posedge i_ref_clk);
    i_rate_fast <= fast;
    wait_fall(n);
    wait_fall(n);
    check("period", n, exp);
  endtask : t_period
  // Enable low for 100 cycles must stretch one period by that much, within 10 cycles
  task automatic t_freeze();
    int n;
    wait_fall(n);
    i_clk_en <= 1'b0;
    repeat (100) @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    wait_fall(n);
    check("frozen period", n inside {[4990:5010]}, 1'b1);
  endtask : t_freeze
  task automatic t_cal();
    int n;
    wait_fall(n);
    host.clock_bits(26, bits);
    repeat (3) @(posedge i_ref_clk);
    check("pulse 25 high", bits[1], 1'b1);
    check("cal ctrl", {o_ctrl.analog_disconnect, o_ctrl.calibrating, dout}, 3'b111);
    wait_fall(n);
    check("cal time", n inside {[288:302]}, 1'b1);
    check("cal ctrl end", o_ctrl, 4'h0);
  endtask : t_cal
  task automatic t_standby();
    int n;
    wait_fall(n);
    host.clock_bits(5, bits);
    host.hold(1'b1);
    repeat (1990) @(posedge i_ref_clk);
    check("early standby", o_ctrl.standby, 1'b0);
    repeat (30) @(posedge i_ref_clk);
    check("standby", {o_ctrl.analog_power_down, o_ctrl.standby, dout}, 3'b111);
    repeat (6000) @(posedge i_ref_clk);
    check("standby held", {o_ctrl.analog_power_down, o_ctrl.standby, dout}, 3'b111);
    host.hold(1'b0);
    wait_fall(n);
    check("wake time", n inside {[198:210]}, 1'b1);
    check("awake", o_ctrl, 4'h0);
  endtask : t_standby
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_read(24'sh012345, 20'h12345);
    t_read(24'sh7fffff, 20'h7ffff);
    t_read(24'sh800000, 20'h80000);
    t_read(24'shfff00f, 20'hff00f);
    t_short();
    t_period(1'b1, 5000);
    t_period(1'b0, 6000);
    t_period(1'b1, 5000);
    t_freeze();
    t_cal();
    t_standby();
    conclude();
  end
endmodule : tb
